/* rtl/timer_event_counter_pair.sv */
// timer/event counter pair: 8-bit counter 0, 16-bit counter 1, apb register slave
//
// Our own choice: the APB register port.
`default_nettype none

module timer_event_counter_pair
   import tec_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ctr0_external_input,
   input  wire logic        ctr1_external_input,
   input  wire logic        rc_osc,
   output logic             ctr0_irq,
   output logic             ctr1_irq,
   output logic             wake
);

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic presc_hit(input logic [6:0] cnt, input logic [2:0] code, input logic [2:0] max_code);
      logic [2:0] c;
      logic [6:0] mask;
      c    = (code > max_code) ? max_code : code;
      mask = 7'((8'h01 << c) - 8'h01);
      return (cnt & mask) == mask;
   endfunction : presc_hit

   function automatic logic count_step(input ctrl_t c, input logic rise, input logic fall,
                                       input logic tick, input logic meas);
      case (c.mode)
         MODE_EVENT: return c.run_enable & (c.edge_select ? fall : rise);
         MODE_TIMER: return c.run_enable & tick;
         MODE_PULSE: return c.run_enable & meas & tick;
         default:    return 1'b0;
      endcase
   endfunction : count_step

   // ************************************************************
   // apb decode
   // ************************************************************
   logic [5:0]  idx;
   logic        aligned;
   logic        access;
   logic        wr_irq, wr_c0, wr_c0c, wr_c1h, wr_c1l, wr_c1c, rd_c1h;
   logic        block0, block1;
   logic        pready_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;

   assign idx     = paddr[7:2];
   assign aligned = paddr[1:0] == 2'h0;
   assign access  = psel & penable & pready_q;
   assign wr_irq  = access & pwrite & aligned & (idx == IDX_IRQ_CONTROL);
   assign wr_c0   = access & pwrite & aligned & (idx == IDX_CTR0_VALUE);
   assign wr_c0c  = access & pwrite & aligned & (idx == IDX_CTR0_CONTROL);
   assign wr_c1h  = access & pwrite & aligned & (idx == IDX_CTR1_HIGH);
   assign wr_c1l  = access & pwrite & aligned & (idx == IDX_CTR1_LOW);
   assign wr_c1c  = access & pwrite & aligned & (idx == IDX_CTR1_CONTROL);
   assign rd_c1h  = access & ~pwrite & aligned & (idx == IDX_CTR1_HIGH);
   // held over setup and access so the value read and the low-byte latch agree
   assign block0  = psel & ~pwrite & aligned & (idx == IDX_CTR0_VALUE);
   assign block1  = psel & ~pwrite & aligned & (idx == IDX_CTR1_HIGH);

   // ************************************************************
   // state
   // ************************************************************
   ctrl_t       ctl0_q, ctl1_q;
   logic [7:0]  ctr0_q, pre0_q;
   logic [15:0] ctr1_q, pre1_q;
   logic [7:0]  buf1_q;
   logic [6:0]  psc0_q, psc1_q;
   logic [1:0]  sdiv_q;
   logic        rc_prev_q, in0_prev_q, in1_prev_q;
   logic        meas0_q, meas1_q;
   logic        en0_q, en1_q, flag0_q, flag1_q;
   logic        irq0_q, irq1_q, wake_q;

   // ************************************************************
   // clock sources and prescalers
   // ************************************************************
   logic rc_tick, sys4_tick, src0, src1, tick0, tick1;
   logic rise0, fall0, rise1, fall1;

   assign rc_tick   = rc_osc & ~rc_prev_q;
   assign sys4_tick = sdiv_q == SYS_DIV_LAST;
   assign src0      = ctl0_q.clock_source ? rc_tick : 1'b1;
   assign src1      = ctl1_q.clock_source ? rc_tick : sys4_tick;
   assign tick0     = src0 & presc_hit(psc0_q, ctl0_q.prescale, CTR0_PSC_MAX);
   assign tick1     = src1 & presc_hit(psc1_q, ctl1_q.prescale, CTR1_PSC_MAX);
   assign rise0     = ctr0_external_input & ~in0_prev_q;
   assign fall0     = ~ctr0_external_input & in0_prev_q;
   assign rise1     = ctr1_external_input & ~in1_prev_q;
   assign fall1     = ~ctr1_external_input & in1_prev_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sdiv_q     <= 2'h0;
         rc_prev_q  <= 1'b0;
         in0_prev_q <= 1'b0;
         in1_prev_q <= 1'b0;
      end else begin
         sdiv_q     <= sdiv_q + 2'h1;
         rc_prev_q  <= rc_osc;
         in0_prev_q <= ctr0_external_input;
         in1_prev_q <= ctr1_external_input;
      end
   end

   // prescalers run free so a code change takes effect within one period
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         psc0_q <= 7'h00;
         psc1_q <= 7'h00;
      end else begin
         if (src0) begin
            psc0_q <= psc0_q + 7'h01;
         end
         if (src1) begin
            psc1_q <= psc1_q + 7'h01;
         end
      end
   end

   // ************************************************************
   // pulse-width measurement state
   // ************************************************************
   logic start0, stop0, start1, stop1, pulse0, pulse1;

   assign pulse0 = (ctl0_q.mode == MODE_PULSE) & ctl0_q.run_enable;
   assign pulse1 = (ctl1_q.mode == MODE_PULSE) & ctl1_q.run_enable;
   assign start0 = pulse0 & ~meas0_q & (ctl0_q.edge_select ? rise0 : fall0);
   assign stop0  = pulse0 & meas0_q & (ctl0_q.edge_select ? fall0 : rise0);
   assign start1 = pulse1 & ~meas1_q & (ctl1_q.edge_select ? rise1 : fall1);
   assign stop1  = pulse1 & meas1_q & (ctl1_q.edge_select ? fall1 : rise1);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meas0_q <= 1'b0;
         meas1_q <= 1'b0;
      end else begin
         meas0_q <= pulse0 & (start0 | (meas0_q & ~stop0));
         meas1_q <= pulse1 & (start1 | (meas1_q & ~stop1));
      end
   end

   // ************************************************************
   // control registers
   // ************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl0_q <= ctrl_t'(CONTROL_RESET);
         ctl1_q <= ctrl_t'(CONTROL_RESET);
      end else begin
         // a software write in the same cycle overrides the automatic clear
         if (wr_c0c) begin
            ctl0_q <= ctrl_t'(pwdata[7:0]);
         end else if (stop0) begin
            ctl0_q.run_enable <= 1'b0;
         end
         if (wr_c1c) begin
            ctl1_q <= ctrl_t'(pwdata[7:0]);
         end else if (stop1) begin
            ctl1_q.run_enable <= 1'b0;
         end
      end
   end

   // ************************************************************
   // counters
   // ************************************************************
   logic inc0, inc1, ovf0, ovf1;

   assign inc0 = count_step(ctl0_q, rise0, fall0, tick0, meas0_q) & ~block0;
   assign inc1 = count_step(ctl1_q, rise1, fall1, tick1, meas1_q) & ~block1;
   assign ovf0 = inc0 & (&ctr0_q);
   assign ovf1 = inc1 & (&ctr1_q);

   // contents are zero after reset only to keep simulation clean; software must load first
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctr0_q <= 8'h00;
         pre0_q <= 8'h00;
      end else begin
         if (wr_c0) begin
            pre0_q <= pwdata[7:0];
         end
         if (wr_c0 & ~ctl0_q.run_enable) begin
            ctr0_q <= pwdata[7:0];
         end else if (ovf0) begin
            ctr0_q <= pre0_q;
         end else if (inc0) begin
            ctr0_q <= ctr0_q + 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctr1_q <= 16'h0000;
         pre1_q <= 16'h0000;
         buf1_q <= 8'h00;
      end else begin
         if (wr_c1l) begin
            buf1_q <= pwdata[7:0];
         end else if (rd_c1h) begin
            buf1_q <= ctr1_q[7:0];
         end
         if (wr_c1h) begin
            pre1_q <= {pwdata[7:0], buf1_q};
         end
         if (wr_c1h & ~ctl1_q.run_enable) begin
            ctr1_q <= {pwdata[7:0], buf1_q};
         end else if (ovf1) begin
            ctr1_q <= pre1_q;
         end else if (inc1) begin
            ctr1_q <= ctr1_q + 16'h0001;
         end
      end
   end

   // ************************************************************
   // interrupt control, flags and wake-up
   // ************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         en0_q   <= 1'b0;
         en1_q   <= 1'b0;
         flag0_q <= 1'b0;
         flag1_q <= 1'b0;
      end else begin
         if (wr_irq) begin
            en0_q <= pwdata[BIT_CTR0_IRQ_ENABLE];
            en1_q <= pwdata[BIT_CTR1_IRQ_ENABLE];
         end
         // writing 0 clears a flag, an overflow in the same cycle still sets it
         flag0_q <= ovf0 | (flag0_q & ~(wr_irq & ~pwdata[BIT_CTR0_FLAG]));
         flag1_q <= ovf1 | (flag1_q & ~(wr_irq & ~pwdata[BIT_CTR1_FLAG]));
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq0_q <= 1'b0;
         irq1_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         irq0_q <= flag0_q & en0_q;
         irq1_q <= flag1_q & en1_q;
         wake_q <= ovf0 | ovf1;
      end
   end

   // ************************************************************
   // apb response, no wait state; read data is registered in the setup cycle so it comes from a flop
   // ************************************************************
   logic [31:0] rd_mux;
   logic        mapped;

   always_comb begin
      rd_mux = 32'h0000_0000;
      mapped = aligned;
      case (idx)
         IDX_IRQ_CONTROL:  rd_mux[7:0] = 8'({flag1_q, flag0_q, 3'h0, en1_q, en0_q});
         IDX_CTR0_VALUE:   rd_mux[7:0] = ctr0_q;
         IDX_CTR0_CONTROL: rd_mux[7:0] = ctl0_q;
         IDX_CTR1_HIGH:    rd_mux[7:0] = ctr1_q[15:8];
         IDX_CTR1_LOW:     rd_mux[7:0] = buf1_q;
         IDX_CTR1_CONTROL: rd_mux[7:0] = ctl1_q;
         default:          mapped = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         pready_q  <= psel & ~penable & ~pready_q;
         if (psel & ~penable) begin
            prdata_q  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_q <= ~mapped;
         end else if (access) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
         end
      end
   end

   assign prdata   = prdata_q;
   assign pready   = pready_q;
   assign pslverr  = pslverr_q;
   assign ctr0_irq = irq0_q;
   assign ctr1_irq = irq1_q;
   assign wake     = wake_q;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence pulse_start1_s;
      start1 & ~wr_c1c;
   endsequence
   sequence pulse_stop1_s;
      stop1 & ~wr_c1c;
   endsequence

   ovf_reload_a: assert property (ovf0 & ~wr_c0 |=> ctr0_q == $past(pre0_q))
      else $error("counter 0 not reloaded on overflow");
   ovf_flag_a: assert property (ovf1 |=> flag1_q ##1 irq1_q == $past(en1_q))
      else $error("counter 1 overflow flag not set");
   halt_count_a: assert property (~ctl0_q.run_enable & ~wr_c0 |=> $stable(ctr0_q))
      else $error("stopped counter 0 changed");
   mode_zero_a: assert property (ctl1_q.mode == MODE_UNUSED & ~wr_c1h |=> $stable(ctr1_q))
      else $error("counter 1 moved in unused mode");
   event_rise_a: assert property (ctl1_q.mode == MODE_EVENT & ctl1_q.run_enable & ~ctl1_q.edge_select
                                  & rise1 & ~block1 & ~(&ctr1_q) & ~wr_c1h
                                  |=> ctr1_q == $past(ctr1_q) + 16'h0001)
      else $error("event edge not counted");
   pulse_start_a: assert property (pulse_start1_s |=> meas1_q & ctl1_q.run_enable)
      else $error("measurement did not start");
   pulse_stop_a: assert property (pulse_stop1_s |=> ~ctl1_q.run_enable ##1 $stable(ctr1_q) || $past(wr_c1h))
      else $error("run enable not cleared after measurement");
   read_block_a: assert property (block0 |=> $stable(ctr0_q))
      else $error("counter 0 moved during read");
   stopped_load_a: assert property (wr_c0 & ~ctl0_q.run_enable |=> ctr0_q == $past(pwdata[7:0]))
      else $error("stopped counter 0 not loaded");
   pair_write_a: assert property (wr_c1h |=> pre1_q == {$past(pwdata[7:0]), $past(buf1_q)})
      else $error("counter 1 preload pair wrong");
   irq_gate_a: assert property (~en0_q |=> ~irq0_q)
      else $error("disabled counter 0 interrupt raised");
   wake_pulse_a: assert property (ovf0 | ovf1 |=> wake_q)
      else $error("no wake-up after overflow");

endmodule : timer_event_counter_pair

`default_nettype wire

/* rtl/tec_pkg.sv */
// package: register map, control fields and timing constants of the timer/event counter pair
// Operation
// - counter 1 prescaler codes divide by 1..16
// - event mode counts on selected input edge
// - pulse mode starts/stops on opposite edges
// - counting only while run-enable bit 4 set
// - bit 5 picks sysclk/4 or RC oscillator (counter 0 uses sysclk undivided instead of sysclk/4)
// - bits 7:6 select event, timer, pulse mode
// - pulse mode reacts to edges, not levels
// - overflow reloads preload and requests interrupt
// - pulse mode clears run-enable after measurement
// - overflow of either counter wakes the device
// - interrupt enable 0 blocks overflow interrupt
// - stopped counter loads written preload value
// - running counter keeps count, preload only updated
// - counter reads freeze counting during access
// - counters run up to all ones then overflow
// - low byte buffered, high byte write transfers both
// - high read latches low byte into buffer
// - overflow flags at bits 5 and 6
`default_nettype none

package tec_pkg;

   // ************************************************************
   // register indices, byte address is four times the index
   // ************************************************************
   localparam logic [5:0] IDX_IRQ_CONTROL   = 6'h0b;
   localparam logic [5:0] IDX_CTR0_VALUE    = 6'h0d;
   localparam logic [5:0] IDX_CTR0_CONTROL  = 6'h0e;
   localparam logic [5:0] IDX_CTR1_HIGH     = 6'h0f;
   localparam logic [5:0] IDX_CTR1_LOW      = 6'h10;
   localparam logic [5:0] IDX_CTR1_CONTROL  = 6'h11;

   // ************************************************************
   // fields and codes
   // ************************************************************
   localparam int         BIT_CTR0_IRQ_ENABLE = 0;
   localparam int         BIT_CTR1_IRQ_ENABLE = 1;
   localparam int         BIT_CTR0_FLAG       = 5;
   localparam int         BIT_CTR1_FLAG       = 6;
   localparam logic [1:0] MODE_UNUSED         = 2'h0;
   localparam logic [1:0] MODE_EVENT          = 2'h1;
   localparam logic [1:0] MODE_TIMER          = 2'h2;
   localparam logic [1:0] MODE_PULSE          = 2'h3;
   localparam logic [2:0] CTR0_PSC_MAX        = 3'h6;
   localparam logic [2:0] CTR1_PSC_MAX        = 3'h4;
   localparam logic [7:0] CONTROL_RESET       = 8'h00;
   localparam logic [1:0] SYS_DIV_LAST        = 2'h3;

   // ************************************************************
   // control register layout, bit 7 down to bit 0
   // ************************************************************
   typedef struct packed {
      logic [1:0] mode;
      logic       clock_source;
      logic       run_enable;
      logic       edge_select;
      logic [2:0] prescale;
   } ctrl_t;

endpackage : tec_pkg

`default_nettype wire

/* verif/ext_signal_source.sv */
// partner model: external event and pulse source for both counters, free-running internal rc oscillator
`default_nettype none

module ext_signal_source (
   input  wire logic core_clk,
   input  wire logic rst_n,
   output var logic  ctr0_external_input,
   output var logic  ctr1_external_input,
   output logic      rc_osc
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0] rc_div_q;

   // ************************************************************
   // rc oscillator
   // ************************************************************
   // runs free: an on-chip oscillator has no frames to stand still between
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rc_div_q <= 3'h0;
         rc_osc   <= 1'b0;
      end else begin
         rc_div_q <= rc_div_q + 3'h1;
         if (rc_div_q == 3'h7) begin
            rc_osc <= ~rc_osc;
         end
      end
   end

   // ************************************************************
   // pin levels
   // ************************************************************
   // both pins idle low until a scenario moves them
   initial begin
      ctr0_external_input = 1'b0;
      ctr1_external_input = 1'b0;
   end

   // new level lands just after an edge, then holds for the given number of cycles
   task automatic set_level(input logic v, input int cycles);
      @(posedge core_clk);
      ctr1_external_input <= v;
      repeat (cycles) @(posedge core_clk);
   endtask : set_level

   task automatic set_level0(input logic v, input int cycles);
      @(posedge core_clk);
      ctr0_external_input <= v;
      repeat (cycles) @(posedge core_clk);
   endtask : set_level0

endmodule : ext_signal_source

`default_nettype wire

/* verif/tb.sv */
// testbench: apb register tests of the timer/event counter pair
`default_nettype none

`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
   $display("ERROR at %0t: mismatch, got %h expected %h", $time, (got), (exp)); end end

module tb;
   import tec_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, rerr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic        ctr0_external_input, ctr1_external_input, rc_osc, ctr0_irq, ctr1_irq, wake;
   logic [15:0] val16, v0;
   int          bad_count, comparisons, wake_cnt, w0, n, e, k, div;

   timer_event_counter_pair i_dut (
      .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ctr0_external_input(ctr0_external_input), .ctr1_external_input(ctr1_external_input),
      .rc_osc(rc_osc), .ctr0_irq(ctr0_irq), .ctr1_irq(ctr1_irq), .wake(wake));

   ext_signal_source i_src (
      .core_clk(core_clk), .rst_n(rst_n), .ctr0_external_input(ctr0_external_input),
      .ctr1_external_input(ctr1_external_input), .rc_osc(rc_osc));

   // ************************************************************
   // clock, wake monitor, watchdog
   // ************************************************************
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   initial wake_cnt = 0;
   always @(posedge core_clk) begin
      if (wake === 1'b1) begin
         wake_cnt <= wake_cnt + 1;
      end
   end

   // whole sequence needs roughly 2500 cycles, so this leaves a wide margin
   initial begin
      #(40 * 60000);
      bad_count++;
      finish_test();
   end

   // ************************************************************
   // apb master
   // ************************************************************
   // request held until the rising edge at which pready is sampled high
   task automatic xfer(input logic [5:0] idx, input logic w, input logic [7:0] d);
      int t;
      t = 0;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h0, d};
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) begin
         t++;
         if (t > 50) begin
            bad_count++;
            finish_test();
         end
         @(posedge core_clk);
      end
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   // high byte first: that read latches the low byte into the buffer
   task automatic rd16();
      xfer(IDX_CTR1_HIGH, 1'b0, 8'h00);
      val16[15:8] = rdata[7:0];
      xfer(IDX_CTR1_LOW, 1'b0, 8'h00);
      val16[7:0] = rdata[7:0];
   endtask : rd16

   task automatic finish_test();
      $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      bad_count = 0;
      comparisons = 0;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      xfer(IDX_CTR1_CONTROL, 1'b0, 8'h00);
      `CHECK(rdata[7:0], CONTROL_RESET)
      xfer(IDX_IRQ_CONTROL, 1'b0, 8'h00);
      `CHECK(rdata[7:0], 8'h00)
      xfer(6'h3f, 1'b1, 8'h5a);
      `CHECK({rerr, rdata}, {1'b1, 32'h0})
      // counter 0 timer on undivided clock, 16 counts from f0 to overflow
      xfer(IDX_CTR0_VALUE, 1'b1, 8'hf0);
      xfer(IDX_IRQ_CONTROL, 1'b1, 8'h01);
      w0 = wake_cnt;
      xfer(IDX_CTR0_CONTROL, 1'b1, 8'h90);
      n = 0;
      while (ctr0_irq !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      `CHECK(n < 30, 1'b1)
      xfer(IDX_IRQ_CONTROL, 1'b0, 8'h00);
      `CHECK(rdata[7:0], 8'h21)
      `CHECK(wake_cnt > w0, 1'b1)
      xfer(IDX_CTR0_CONTROL, 1'b1, 8'h80);
      xfer(IDX_CTR0_VALUE, 1'b0, 8'h00);
      `CHECK(rdata[7:0] >= 8'hf0, 1'b1)
      xfer(IDX_IRQ_CONTROL, 1'b1, 8'h01);
      repeat (3) @(posedge core_clk);
      `CHECK(ctr0_irq, 1'b0)
      // counter 1 event mode, both edge selects, irq enable off then on
      for (e = 0; e < 2; e++) begin
         xfer(IDX_IRQ_CONTROL, 1'b1, {6'h0, e[0], 1'b0});
         xfer(IDX_CTR1_CONTROL, 1'b1, {MODE_EVENT, 1'b0, 1'b0, e[0], 3'h0});
         xfer(IDX_CTR1_LOW, 1'b1, 8'hfd);
         xfer(IDX_CTR1_HIGH, 1'b1, 8'hff);
         rd16();
         `CHECK(val16, 16'hfffd)
         xfer(IDX_CTR1_CONTROL, 1'b1, {MODE_EVENT, 1'b0, 1'b1, e[0], 3'h0});
         i_src.set_level(1'b1, 4);
         rd16();
         `CHECK(val16, 16'hfffd + {15'h0, ~e[0]})
         i_src.set_level(1'b0, 4);
         rd16();
         `CHECK(val16, 16'hfffe)
         xfer(IDX_CTR1_LOW, 1'b1, 8'h10);
         xfer(IDX_CTR1_HIGH, 1'b1, 8'h20);
         rd16();
         `CHECK(val16, 16'hfffe)
         for (k = 0; k < 2; k++) begin
            i_src.set_level(1'b1, 4);
            i_src.set_level(1'b0, 4);
         end
         rd16();
         `CHECK(val16, 16'h2010)
         xfer(IDX_IRQ_CONTROL, 1'b0, 8'h00);
         `CHECK(rdata[7:0], {1'b0, 1'b1, 4'h0, e[0], 1'b0})
         `CHECK(ctr1_irq, e[0])
      end
      // run bit off, then mode 00 with run bit on: edges must not count
      for (k = 0; k < 2; k++) begin
         xfer(IDX_CTR1_CONTROL, 1'b1, (k == 0) ? 8'h48 : 8'h18);
         rd16();
         v0 = val16;
         i_src.set_level(1'b1, 4);
         i_src.set_level(1'b0, 4);
         rd16();
         `CHECK(val16, v0)
      end
      // pulse width: 41 cycles high on core_clk/4 gives about 10 counts
      xfer(IDX_CTR1_CONTROL, 1'b1, 8'hc8);
      xfer(IDX_CTR1_LOW, 1'b1, 8'h00);
      xfer(IDX_CTR1_HIGH, 1'b1, 8'h00);
      xfer(IDX_CTR1_CONTROL, 1'b1, 8'hd8);
      i_src.set_level(1'b1, 40);
      i_src.set_level(1'b0, 4);
      xfer(IDX_CTR1_CONTROL, 1'b0, 8'h00);
      `CHECK(rdata[7:0], 8'hc8)
      rd16();
      `CHECK(val16 >= 16'd9 && val16 <= 16'd11, 1'b1)
      v0 = val16;
      i_src.set_level(1'b1, 40);
      i_src.set_level(1'b0, 4);
      rd16();
      `CHECK(val16, v0)
      // prescaler codes 000..101 on core_clk/4, then rc source; tolerance covers the apb cycles
      for (k = 0; k < 7; k++) begin
         div = (k == 6) ? 16 : (4 << ((k > 4) ? 4 : k));
         xfer(IDX_CTR1_CONTROL, 1'b1, {MODE_TIMER, k == 6, 2'b00, (k == 6) ? 3'h0 : k[2:0]});
         xfer(IDX_CTR1_LOW, 1'b1, 8'h00);
         xfer(IDX_CTR1_HIGH, 1'b1, 8'h00);
         xfer(IDX_CTR1_CONTROL, 1'b1, {MODE_TIMER, k == 6, 2'b10, (k == 6) ? 3'h0 : k[2:0]});
         repeat (256) @(posedge core_clk);
         xfer(IDX_CTR1_CONTROL, 1'b1, {MODE_TIMER, k == 6, 2'b00, (k == 6) ? 3'h0 : k[2:0]});
         rd16();
         `CHECK(val16 + 1 >= 256 / div && val16 <= 256 / div + 2, 1'b1)
      end
      // counter 0 low pulse, start on falling edge, core_clk/8: 65 low cycles give 8 or 9 counts
      i_src.set_level0(1'b1, 4);
      xfer(IDX_CTR0_VALUE, 1'b1, 8'h00);
      xfer(IDX_CTR0_CONTROL, 1'b1, 8'hd3);
      i_src.set_level0(1'b0, 64);
      i_src.set_level0(1'b1, 4);
      xfer(IDX_CTR0_CONTROL, 1'b0, 8'h00);
      `CHECK(rdata[7:0], 8'hc3)
      xfer(IDX_CTR0_VALUE, 1'b0, 8'h00);
      `CHECK(rdata[7:0] >= 8'h08 && rdata[7:0] <= 8'h09, 1'b1)
      finish_test();
   end

endmodule : tb

`default_nettype wire
